// >>> core/accel_readout.sv
// Purpose: sample queue, result bytes and status byte of the sensor
// Assumes: samples and motion conditions arrive on CORE_CLK
// Notes:   host access crosses from LINK_CLK by toggle handshake
`timescale 1ns/1ps
`default_nettype none
module accel_readout #(
  parameter logic [5:0] LEVEL_THRESH = accel_pkg::LEVEL_THRESH_DEF
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SAMPLE_VALID,
  input  wire logic [15:0] SAMPLE_X,
  input  wire logic [15:0] SAMPLE_Y,
  input  wire logic [15:0] SAMPLE_Z,
  input  wire logic        WAKE_ACTIVE,
  input  wire logic [4:0]  MOTION_COND,
  input  wire logic        LINK_CLK,
  input  wire logic        LINK_RST,
  input  wire logic        LINK_FRAME,
  input  wire logic        LINK_REQ,
  input  wire logic        LINK_WR,
  input  wire logic [7:0]  LINK_ADDR,
  input  wire logic [7:0]  LINK_WDATA,
  output logic             LINK_ACK,
  output logic [7:0]       LINK_RDATA
);
  typedef struct packed {
    logic        frame_s1;
    logic        frame_s2;
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        ack_tgl;
    logic [7:0]  rdata;
    logic [7:0]  motion_ctrl;
    logic [7:0]  queue_cfg;
    logic [5:0]  wr_idx;
    logic [5:0]  rd_idx;
    logic [15:0] pend_x;
    logic [15:0] pend_y;
    logic [15:0] pend_z;
    logic        pend_new;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [5:0]  wr_view;
    logic [2:0]  qs_view;
    logic        q_flag_view;
    logic [4:0]  cond_view;
    logic        new_flag;
  } core_s;

  core_s r_r;
  core_s r_nxt;
  logic [47:0] qmem [accel_pkg::QUEUE_DEPTH];

  logic        req_tgl;
  logic [7:0]  lnk_addr;
  logic        lnk_wr;
  logic [7:0]  lnk_wdata;
  logic        req_evt;
  logic        freeze;
  logic        queue_on;
  logic [2:0]  qs_live;
  logic [47:0] res_word;
  logic [2:0]  byte_sel;
  logic [7:0]  res_byte;
  logic [7:0]  rd_val;
  logic [4:0]  cond_mask;
  logic        stat_rd;
  logic        q_adv;
  logic        ovr;

  function automatic logic [5:0] q_level(input logic [5:0] w, input logic [5:0] rd);
    q_level = 6'(w - rd);
  endfunction

  function automatic logic q_empty(input logic [5:0] w, input logic [5:0] rd);
    q_empty = (w == rd);
  endfunction

  function automatic logic q_full(input logic [5:0] w, input logic [5:0] rd);
    q_full = (w[4:0] == rd[4:0]) && (w[5] != rd[5]);
  endfunction

  link_port u_link (
    .link_clk   (LINK_CLK),
    .link_rst   (LINK_RST),
    .req        (LINK_REQ),
    .wr         (LINK_WR),
    .addr       (LINK_ADDR),
    .wdata      (LINK_WDATA),
    .ack_tgl    (r_r.ack_tgl),
    .core_rdata (r_r.rdata),
    .req_tgl    (req_tgl),
    .hold_addr  (lnk_addr),
    .hold_wr    (lnk_wr),
    .hold_wdata (lnk_wdata),
    .ack        (LINK_ACK),
    .rdata      (LINK_RDATA)
  );

  // held fields are stable from the req toggle until the ack returns
  assign req_evt = r_r.req_s2 ^ r_r.req_s3;
  assign freeze = r_r.frame_s2;
  assign queue_on = r_r.queue_cfg[accel_pkg::QCFG_EN_BIT];
  assign stat_rd = req_evt && !lnk_wr && (lnk_addr == accel_pkg::FLAGS_OFS);

  always_comb
  begin
    qs_live = '0;
    qs_live[accel_pkg::QS_EMPTY_BIT] = q_empty(r_r.wr_idx, r_r.rd_idx);
    qs_live[accel_pkg::QS_FULL_BIT] = q_full(r_r.wr_idx, r_r.rd_idx);
    qs_live[accel_pkg::QS_LEVEL_BIT] = q_level(r_r.wr_idx, r_r.rd_idx) >= LEVEL_THRESH;
  end

  always_comb
  begin
    cond_mask = '0;
    cond_mask[accel_pkg::ST_TILT_BIT] = r_r.motion_ctrl[accel_pkg::MC_LEAN_BIT];
    cond_mask[accel_pkg::ST_FLIP_BIT] = r_r.motion_ctrl[accel_pkg::MC_LEAN_BIT];
    cond_mask[accel_pkg::ST_MOVE_BIT] = r_r.motion_ctrl[accel_pkg::MC_MOVE_BIT];
    cond_mask[accel_pkg::ST_SHAKE_BIT] = r_r.motion_ctrl[accel_pkg::MC_SHAKE_BIT];
    cond_mask[accel_pkg::ST_T35_BIT] = r_r.motion_ctrl[accel_pkg::MC_T35_BIT];
  end

  // queued word is laid out like the live results: x low bits first
  assign res_word = queue_on ? qmem[r_r.rd_idx[4:0]] : {r_r.z, r_r.y, r_r.x};
  assign byte_sel = 3'(lnk_addr - accel_pkg::X_LO_OFS);
  assign res_byte = res_word[{byte_sel, 3'b000} +: 8];

  always_comb
  begin
    rd_val = 8'h00;
    if (lnk_addr == accel_pkg::QUEUE_WR_IDX_OFS)
      rd_val = {2'b00, r_r.wr_view};
    else if (lnk_addr == accel_pkg::QUEUE_RD_IDX_OFS)
      rd_val = {2'b00, r_r.rd_idx};
    else if (lnk_addr == accel_pkg::QUEUE_STAT_OFS)
      rd_val = {5'h00, r_r.qs_view};
    else if (lnk_addr >= accel_pkg::X_LO_OFS && lnk_addr <= accel_pkg::Z_HI_OFS)
      rd_val = res_byte;
    else if (lnk_addr == accel_pkg::FLAGS_OFS)
      rd_val = {r_r.new_flag, 1'b0, r_r.q_flag_view, r_r.cond_view};
    else if (lnk_addr == accel_pkg::MOTION_CTRL_OFS)
      rd_val = r_r.motion_ctrl;
    else if (lnk_addr == accel_pkg::QUEUE_CFG_OFS)
      rd_val = r_r.queue_cfg;
  end

  // last byte of a queued burst pops the entry
  assign q_adv = req_evt && !lnk_wr && queue_on && (lnk_addr == accel_pkg::Z_HI_OFS)
                 && !q_empty(r_r.wr_idx, r_r.rd_idx);
  // a full queue drops its oldest entry so the writer never stalls
  assign ovr = SAMPLE_VALID && q_full(r_r.wr_idx, r_r.rd_idx);

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.frame_s1 = LINK_FRAME;
    r_nxt.frame_s2 = r_r.frame_s1;
    r_nxt.req_s1 = req_tgl;
    r_nxt.req_s2 = r_r.req_s1;
    r_nxt.req_s3 = r_r.req_s2;

    // publish deferred results only outside a frame
    if (!freeze)
    begin
      r_nxt.x = r_r.pend_x;
      r_nxt.y = r_r.pend_y;
      r_nxt.z = r_r.pend_z;
      r_nxt.wr_view = r_r.wr_idx;
      r_nxt.qs_view = qs_live;
      r_nxt.q_flag_view = |qs_live;
      r_nxt.cond_view = MOTION_COND & cond_mask;
      r_nxt.pend_new = 1'b0;
    end

    if (SAMPLE_VALID)
    begin
      r_nxt.wr_idx = 6'(r_r.wr_idx + 6'h01);
      r_nxt.pend_x = SAMPLE_X;
      r_nxt.pend_y = SAMPLE_Y;
      r_nxt.pend_z = SAMPLE_Z;
      r_nxt.pend_new = WAKE_ACTIVE || (freeze && r_r.pend_new);
    end
    if (q_adv || ovr)
      r_nxt.rd_idx = 6'(r_r.rd_idx + 6'h01);

    if (req_evt)
    begin
      r_nxt.ack_tgl = ~r_r.ack_tgl;
      r_nxt.rdata = rd_val;
      if (lnk_wr && lnk_addr == accel_pkg::MOTION_CTRL_OFS)
        r_nxt.motion_ctrl = lnk_wdata;
      else if (lnk_wr && lnk_addr == accel_pkg::QUEUE_CFG_OFS)
        r_nxt.queue_cfg = lnk_wdata;
    end

    // clear on status read; a same-cycle publish wins
    if (stat_rd)
      r_nxt.new_flag = 1'b0;
    if (!freeze && r_r.pend_new)
      r_nxt.new_flag = 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      r_r <= '0;
      r_r.motion_ctrl <= accel_pkg::MOTION_CTRL_RST;
      r_r.queue_cfg <= accel_pkg::QUEUE_CFG_RST;
      r_r.rdata <= accel_pkg::RDATA_RST;
      r_r.wr_idx <= accel_pkg::IDX_RST;
      r_r.rd_idx <= accel_pkg::IDX_RST;
      r_r.wr_view <= accel_pkg::IDX_RST;
      r_r.x <= accel_pkg::RESULT_RST;
      r_r.y <= accel_pkg::RESULT_RST;
      r_r.z <= accel_pkg::RESULT_RST;
      r_r.pend_x <= accel_pkg::RESULT_RST;
      r_r.pend_y <= accel_pkg::RESULT_RST;
      r_r.pend_z <= accel_pkg::RESULT_RST;
      r_r.qs_view <= accel_pkg::QSTAT_RST;
    end
    else
      r_r <= r_nxt;
  end

  // storage has no reset; result reads use the entry at rd_idx even when the queue is empty
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST && SAMPLE_VALID)
      qmem[r_r.wr_idx[4:0]] <= {SAMPLE_Z, SAMPLE_Y, SAMPLE_X};
  end

  chk_wr_idx_upper: assert property (@(posedge CORE_CLK) disable iff (RST)
    (req_evt && !lnk_wr && lnk_addr == accel_pkg::QUEUE_WR_IDX_OFS) |=> (r_r.rdata[7:6] == 2'b00))
    else $error("write index upper bits not zero");

  chk_wrap_bound: assert property (@(posedge CORE_CLK) disable iff (RST)
    q_level(r_r.wr_idx, r_r.rd_idx) <= 6'(accel_pkg::QUEUE_DEPTH))
    else $error("queue level beyond depth");

  chk_wr_advance: assert property (@(posedge CORE_CLK) disable iff (RST)
    SAMPLE_VALID |=> (r_r.wr_idx == 6'($past(r_r.wr_idx) + 6'h01)))
    else $error("write index did not advance");

  chk_freeze_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    freeze |=> ($stable(r_r.x) && $stable(r_r.z) && $stable(r_r.wr_view)))
    else $error("readable result changed inside frame");

  chk_pop_on_last: assert property (@(posedge CORE_CLK) disable iff (RST)
    (q_adv && !ovr) |=> (r_r.rd_idx == 6'($past(r_r.rd_idx) + 6'h01)) && $stable(r_r.wr_idx[5:0]) || $past(SAMPLE_VALID))
    else $error("read index did not pop");

  chk_lean_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!freeze && !r_r.motion_ctrl[accel_pkg::MC_LEAN_BIT]) |=> (r_r.cond_view[1:0] == 2'b00))
    else $error("tilt or flip flag while disabled");

  chk_move_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!freeze && !r_r.motion_ctrl[accel_pkg::MC_MOVE_BIT]) |=> !r_r.cond_view[accel_pkg::ST_MOVE_BIT])
    else $error("movement flag while disabled");

  chk_shake_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!freeze && !r_r.motion_ctrl[accel_pkg::MC_SHAKE_BIT]) |=> !r_r.cond_view[accel_pkg::ST_SHAKE_BIT])
    else $error("shake flag while disabled");

  chk_t35_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!freeze && !r_r.motion_ctrl[accel_pkg::MC_T35_BIT]) |=> !r_r.cond_view[accel_pkg::ST_T35_BIT])
    else $error("tilt-35 flag while disabled");

  chk_qflag_or: assert property (@(posedge CORE_CLK) disable iff (RST)
    !freeze |=> (r_r.q_flag_view == |$past(qs_live)))
    else $error("queue flag not OR of queue status");

  chk_new_set: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!freeze && r_r.pend_new) |=> r_r.new_flag ##1 (r_r.new_flag || $past(stat_rd)))
    else $error("new sample flag not set");

  chk_new_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    (stat_rd && !(!freeze && r_r.pend_new)) |=> !r_r.new_flag)
    else $error("new sample flag not cleared by read");

  cov_sample_in_frame: cover property (@(posedge CORE_CLK) disable iff (RST)
    freeze && SAMPLE_VALID ##[1:50] !freeze);
  cov_status_read: cover property (@(posedge CORE_CLK) disable iff (RST)
    r_r.new_flag && stat_rd);
  cov_queue_full: cover property (@(posedge CORE_CLK) disable iff (RST)
    q_full(r_r.wr_idx, r_r.rd_idx));
  cov_queue_pop: cover property (@(posedge CORE_CLK) disable iff (RST)
    q_adv);
endmodule
`default_nettype wire

// >>> core/accel_pkg.sv
// Purpose: shared constants of the sample readout block
// Assumes: byte-wide register map, 32-entry sample queue
// Notes:   offsets are register byte locations
package accel_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IDX_W = 6;
  localparam int QUEUE_DEPTH = 32;
  localparam int SYNC_STAGES = 2;

  localparam logic [7:0] MOTION_CTRL_OFS = 8'h09;
  localparam logic [7:0] QUEUE_STAT_OFS = 8'h0a;
  localparam logic [7:0] QUEUE_RD_IDX_OFS = 8'h0b;
  localparam logic [7:0] QUEUE_WR_IDX_OFS = 8'h0c;
  localparam logic [7:0] X_LO_OFS = 8'h0d;
  localparam logic [7:0] X_HI_OFS = 8'h0e;
  localparam logic [7:0] Y_LO_OFS = 8'h0f;
  localparam logic [7:0] Y_HI_OFS = 8'h10;
  localparam logic [7:0] Z_LO_OFS = 8'h11;
  localparam logic [7:0] Z_HI_OFS = 8'h12;
  localparam logic [7:0] FLAGS_OFS = 8'h13;
  localparam logic [7:0] QUEUE_CFG_OFS = 8'h2d;

  localparam int MC_LEAN_BIT = 0;
  localparam int MC_MOVE_BIT = 2;
  localparam int MC_SHAKE_BIT = 3;
  localparam int MC_T35_BIT = 4;
  localparam int QCFG_EN_BIT = 5;

  localparam int ST_NEW_BIT = 7;
  localparam int ST_QUEUE_BIT = 5;
  localparam int ST_T35_BIT = 4;
  localparam int ST_SHAKE_BIT = 3;
  localparam int ST_MOVE_BIT = 2;
  localparam int ST_FLIP_BIT = 1;
  localparam int ST_TILT_BIT = 0;

  localparam int QS_EMPTY_BIT = 0;
  localparam int QS_FULL_BIT = 1;
  localparam int QS_LEVEL_BIT = 2;

  localparam logic [7:0] MOTION_CTRL_RST = 8'h00;
  localparam logic [7:0] QUEUE_CFG_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [2:0] QSTAT_RST = 3'h1;
  localparam logic [5:0] IDX_RST = 6'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [5:0] LEVEL_THRESH_DEF = 6'h10;
endpackage

// >>> core/link_port.sv
// Purpose: link-clock side of the register access handshake
// Assumes: host holds LINK_REQ fields for the pulse cycle only
// Notes:   one request in flight; a request while busy is dropped
`timescale 1ns/1ps
`default_nettype none
module link_port (
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  input  wire logic       req,
  input  wire logic       wr,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       ack_tgl,
  input  wire logic [7:0] core_rdata,
  output logic            req_tgl,
  output logic [7:0]      hold_addr,
  output logic            hold_wr,
  output logic [7:0]      hold_wdata,
  output logic            ack,
  output logic [7:0]      rdata
);
  typedef struct packed {
    logic       busy;
    logic       req_tgl;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
  } link_s;

  link_s r_r;
  link_s r_nxt;

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.ack_s1 = ack_tgl;
    r_nxt.ack_s2 = r_r.ack_s1;
    r_nxt.ack_s3 = r_r.ack_s2;
    r_nxt.ack = 1'b0;
    // core data is stable once its ack toggle is seen
    if (r_r.busy && (r_r.ack_s2 != r_r.ack_s3))
    begin
      r_nxt.busy = 1'b0;
      r_nxt.ack = 1'b1;
      r_nxt.rdata = core_rdata;
    end
    if (req && !r_r.busy)
    begin
      r_nxt.busy = 1'b1;
      r_nxt.addr = addr;
      r_nxt.wr = wr;
      r_nxt.wdata = wdata;
      r_nxt.req_tgl = ~r_r.req_tgl;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign req_tgl = r_r.req_tgl;
  assign hold_addr = r_r.addr;
  assign hold_wr = r_r.wr;
  assign hold_wdata = r_r.wdata;
  assign ack = r_r.ack;
  assign rdata = r_r.rdata;
endmodule
`default_nettype wire

// >>> verification/link_host.sv
// Purpose: host side of the register link, behavioural
// Assumes: one access in flight, frame level marks bus start to stop
// Notes:   link clock runs only in frames, accesses and reset
`timescale 1ns/1ps
`default_nettype none
module link_host (
  output logic            link_clk,
  output logic            link_rst,
  output logic            frame,
  output logic            req,
  output logic            wr,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic       ack,
  input  wire logic [7:0] rdata
);
  logic run;

  initial
  begin
    link_clk = 1'b0;
    link_rst = 1'b1;
    run = 1'b1;
    frame = 1'b0;
    req = 1'b0;
    wr = 1'b1;
    addr = 8'h5a;
    wdata = 8'ha5;
  end

  // parks low when idle; phase unrelated to the core clock
  initial
  begin
    #3.7;
    forever
    begin
      #6;
      if (run || link_clk)
        link_clk = ~link_clk;
    end
  end

  task automatic reset_on();
    run = 1'b1;
    link_rst = 1'b1;
  endtask

  task automatic reset_off();
    @(posedge link_clk);
    #1;
    link_rst = 1'b0;
    run = frame;
  endtask

  // q stays unknown if no answer comes, so the caller's compare fails
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'hxx;
    run = 1'b1;
    @(posedge link_clk);
    #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge link_clk);
    #1;
    req = 1'b0;
    wr = ~w;
    addr = ~a;
    wdata = ~d;
    do
    begin
      @(negedge link_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack === 1'b1)
      q = rdata;
    @(posedge link_clk);
    #1;
    run = frame;
  endtask

  task automatic frame_set(input logic f);
    run = 1'b1;
    @(posedge link_clk);
    #1;
    frame = f;
    @(posedge link_clk);
    #1;
    run = f;
  endtask

  // whole result set inside one frame, 0x0d through 0x12
  task automatic burst(output logic [47:0] v);
    logic [7:0] q;
    frame_set(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      access(1'b0, 8'(8'h0d + i), 8'h00, q);
      v[8*i +: 8] = q;
    end
    frame_set(1'b0);
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: self-checking bench of the sample readout block
// Assumes: host model drives the link side
// Notes:   sample bytes are low=k, high=a0/b0/c0 per axis
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CORE_CLK;
  logic        RST;
  logic        SAMPLE_VALID;
  logic [15:0] SAMPLE_X;
  logic [15:0] SAMPLE_Y;
  logic [15:0] SAMPLE_Z;
  logic        WAKE_ACTIVE;
  logic [4:0]  MOTION_COND;
  wire         link_clk;
  wire         link_rst;
  wire         link_frame;
  wire         link_req;
  wire         link_wr;
  wire  [7:0]  link_addr;
  wire  [7:0]  link_wdata;
  wire         link_ack;
  wire  [7:0]  link_rdata;
  int          fails;
  int          cmp_count;
  logic [7:0]  en_tab [6] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h1d};
  logic [7:0]  st_tab [6] = '{8'h00, 8'h03, 8'h04, 8'h08, 8'h10, 8'h1f};

  link_host host (.link_clk(link_clk), .link_rst(link_rst), .frame(link_frame), .req(link_req), .wr(link_wr),
    .addr(link_addr), .wdata(link_wdata), .ack(link_ack), .rdata(link_rdata));

  accel_readout uut (.CORE_CLK(CORE_CLK), .RST(RST), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_X(SAMPLE_X),
    .SAMPLE_Y(SAMPLE_Y), .SAMPLE_Z(SAMPLE_Z), .WAKE_ACTIVE(WAKE_ACTIVE), .MOTION_COND(MOTION_COND),
    .LINK_CLK(link_clk), .LINK_RST(link_rst), .LINK_FRAME(link_frame), .LINK_REQ(link_req), .LINK_WR(link_wr),
    .LINK_ADDR(link_addr), .LINK_WDATA(link_wdata), .LINK_ACK(link_ack), .LINK_RDATA(link_rdata));

  initial
  begin
    CORE_CLK = 1'b0;
    forever
      #2.5 CORE_CLK = ~CORE_CLK;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.access(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.access(1'b1, a, d, q);
  endtask

  function automatic logic [7:0] exp_byte(input logic [7:0] k, input int i);
    return (i % 2 == 0) ? k : 8'(8'ha0 + 8'h10 * (i / 2));
  endfunction

  task automatic rd_res(input logic [7:0] k);
    for (int i = 0; i < 6; i++)
      rdc(8'(8'h0d + i), exp_byte(k, i));
  endtask

  task automatic sample(input logic [7:0] k);
    @(posedge CORE_CLK);
    #1;
    SAMPLE_VALID = 1'b1;
    SAMPLE_X = {8'ha0, k};
    SAMPLE_Y = {8'hb0, k};
    SAMPLE_Z = {8'hc0, k};
    @(posedge CORE_CLK);
    #1;
    SAMPLE_VALID = 1'b0;
    SAMPLE_X = ~SAMPLE_X;
    repeat (4) @(posedge CORE_CLK);
  endtask

  // core-domain levels change just after a core edge
  task automatic tick();
    @(posedge CORE_CLK);
    #1;
  endtask

  task automatic do_reset();
    host.reset_on();
    @(posedge CORE_CLK);
    #1;
    RST = 1'b1;
    repeat (6) @(posedge CORE_CLK);
    #1;
    RST = 1'b0;
    host.reset_off();
  endtask

  task automatic t_after_reset();
    rdc(8'h0c, 8'h00);
    for (int i = 0; i < 6; i++)
      rdc(8'(8'h0d + i), 8'h00);
    rdc(8'h13, 8'h20);
    rdc(8'h0a, 8'h01);
    rdc(8'h40, 8'h00);
  endtask

  task automatic t_new_sample();
    tick();
    WAKE_ACTIVE = 1'b1;
    sample(8'h81);
    rdc(8'h0c, 8'h01);
    rd_res(8'h81);
    rdc(8'h13, 8'h80);
    rdc(8'h13, 8'h00);
    tick();
    WAKE_ACTIVE = 1'b0;
    sample(8'h02);
    rdc(8'h13, 8'h00);
    rdc(8'h0c, 8'h02);
    rdc(8'h0d, 8'h02);
  endtask

  task automatic t_motion();
    tick();
    // conditions held steady while polled, so a raw read is meaningful
    MOTION_COND = 5'h1f;
    for (int i = 0; i < 6; i++)
    begin
      wrr(8'h09, en_tab[i]);
      rdc(8'h13, st_tab[i]);
    end
    wrr(8'h09, 8'h00);
    tick();
    MOTION_COND = 5'h00;
  endtask

  task automatic t_freeze();
    tick();
    WAKE_ACTIVE = 1'b1;
    host.frame_set(1'b1);
    sample(8'h33);
    rdc(8'h0d, 8'h02);
    rdc(8'h0c, 8'h02);
    rdc(8'h13, 8'h00);
    host.frame_set(1'b0);
    repeat (8) @(posedge CORE_CLK);
    rdc(8'h0c, 8'h03);
    rd_res(8'h33);
    rdc(8'h13, 8'h80);
  endtask

  task automatic t_queue();
    logic [47:0] v;
    do_reset();
    tick();
    WAKE_ACTIVE = 1'b0;
    wrr(8'h2d, 8'h20);
    for (int k = 0; k < 16; k++)
      sample(8'(k));
    rdc(8'h0a, 8'h04);
    rdc(8'h13, 8'h20);
    for (int k = 16; k < 32; k++)
      sample(8'(k));
    rdc(8'h0a, 8'h06);
    rdc(8'h0c, 8'h20);
    rdc(8'h0b, 8'h00);
    for (int e = 0; e < 2; e++)
    begin
      host.burst(v);
      for (int i = 0; i < 6; i++)
        chk(v[8*i +: 8], exp_byte(8'(e), i));
    end
    rdc(8'h0b, 8'h02);
    rdc(8'h0a, 8'h04);
    // third sample past full overwrites the oldest entry
    for (int k = 32; k < 35; k++)
      sample(8'(k));
    rdc(8'h0b, 8'h03);
    rdc(8'h0a, 8'h06);
    host.burst(v);
    for (int i = 0; i < 6; i++)
      chk(v[8*i +: 8], exp_byte(8'h03, i));
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // whole run is well under a hundred link accesses
  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    fails = 0;
    cmp_count = 0;
    RST = 1'b1;
    SAMPLE_VALID = 1'b0;
    SAMPLE_X = 16'h0000;
    SAMPLE_Y = 16'h0000;
    SAMPLE_Z = 16'h0000;
    WAKE_ACTIVE = 1'b0;
    MOTION_COND = 5'h00;
    do_reset();
    t_after_reset();
    t_new_sample();
    t_motion();
    t_freeze();
    t_queue();
    report_and_stop();
  end
endmodule
`default_nettype wire
